// ---- pkg/csf_pkg.sv ----
// Package with constants, types and carriers of the status flag unit.
package csf_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;

  localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_IREQ = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_ACC = 2'h3;

  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_I = 2;
  localparam int unsigned FLAG_D = 3;
  localparam int unsigned FLAG_B = 4;
  localparam int unsigned FLAG_T = 5;
  localparam int unsigned FLAG_V = 6;
  localparam int unsigned FLAG_N = 7;

  localparam int unsigned IREQ_LSB = 1;

  localparam logic [DATA_W-1:0] PS_RESET = 8'h04;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  typedef enum logic [3:0] {
    CSF_NONE = 4'h0,
    CSF_ADD = 4'h1,
    CSF_SUB = 4'h2,
    CSF_SET_CARRY = 4'h3,
    CSF_CLR_CARRY = 4'h4,
    CSF_SET_DEC = 4'h5,
    CSF_CLR_DEC = 4'h6,
    CSF_SET_MASK = 4'h7,
    CSF_CLR_MASK = 4'h8,
    CSF_PUSH_PS = 4'h9,
    CSF_PULL_PS = 4'ha,
    CSF_BREAK = 4'hb,
    CSF_NOP = 4'hc
  } csf_op_t;

  typedef struct packed {
    logic valid;
    csf_op_t code;
    logic [DATA_W-1:0] data;
  } csf_op_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } csf_bus_req_t;

endpackage

// ---- logic/csf_bcd_alu.sv ----
// Binary and decimal adder/subtractor for the status flag unit.
`timescale 1ns/1ps
module csf_bcd_alu (
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic doSub,
  input wire logic decMode,
  output logic [7:0] result,
  output logic carryOut,
  output logic ovfOut
);

  logic [7:0] bEff;
  logic [8:0] binSum;
  logic [4:0] lo;
  logic [4:0] hi;
  logic halfC;

  always_comb begin
    bEff = doSub ? ~opB : opB;
    binSum = {1'b0, opA} + {1'b0, bEff} + {8'h00, carryIn};
    ovfOut = (opA[7] == bEff[7]) && (binSum[7] != opA[7]);
    lo = 5'h00;
    hi = 5'h00;
    halfC = 1'b0;
    result = binSum[7:0];
    carryOut = binSum[8];
    // Decimal correction applies only when the decimal flag is set.
    if (decMode && !doSub) begin
      lo = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
      halfC = (lo > 5'h09);
      if (halfC) begin
        lo = lo + 5'h06;
      end
      hi = {1'b0, opA[7:4]} + {1'b0, opB[7:4]} + {4'h0, halfC};
      carryOut = (hi > 5'h09);
      if (carryOut) begin
        hi = hi + 5'h06;
      end
      result = {hi[3:0], lo[3:0]};
    end else if (decMode) begin
      lo = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, ~carryIn};
      halfC = lo[4];
      if (halfC) begin
        lo = lo - 5'h06;
      end
      hi = {1'b0, opA[7:4]} - {1'b0, opB[7:4]} - {4'h0, halfC};
      carryOut = ~hi[4];
      if (hi[4]) begin
        hi = hi - 5'h06;
      end
      result = {hi[3:0], lo[3:0]};
    end
  end

endmodule

// ---- logic/cpu_status_flag_logic.sv ----
// Status register, decimal arithmetic flags and interrupt request logic.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cpu_status_flag_logic #(
  parameter int unsigned NUM_EXT = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input csf_pkg::csf_bus_req_t busReq,
  output logic [7:0] rdData,
  input csf_pkg::csf_op_req_t opReq,
  input wire logic [NUM_EXT-1:0] extIntPin,
  output logic [7:0] status,
  output logic [7:0] accOut,
  output logic [7:0] stackData,
  output logic stackWr,
  output logic vecTake,
  output logic entryBrk
);

  generate
    if (NUM_EXT < 1 || NUM_EXT > 7) begin : g_bad
      $error("NUM_EXT must lie between 1 and 7");
    end
  endgenerate

  function automatic logic isBcd(input logic [7:0] x);
    isBcd = (x[7:4] < 4'ha) && (x[3:0] < 4'ha);
  endfunction

  function automatic logic [7:0] bcdVal(input logic [7:0] x);
    bcdVal = ({4'h0, x[7:4]} << 3) + ({4'h0, x[7:4]} << 1) + {4'h0, x[3:0]};
  endfunction

  logic [7:0] ps_r;
  logic [7:0] acc_r;
  logic [7:0] rdData_r;
  logic [7:0] stackData_r;
  logic stackWr_r;
  logic vecTake_r;
  logic entryBrk_r;
  logic [NUM_EXT-1:0] ireq_r;
  logic [NUM_EXT-1:0] ireq_nxt;
  logic [NUM_EXT-1:0] ireqSeen_r;
  logic [NUM_EXT-1:0] edgeSel_r;
  logic [NUM_EXT-1:0] sync1_r;
  logic [NUM_EXT-1:0] sync2_r;
  logic [NUM_EXT-1:0] lvl_r;
  logic [NUM_EXT-1:0] detect;
  logic [NUM_EXT-1:0] rise;
  logic [NUM_EXT-1:0] clrBus;
  logic [NUM_EXT-1:0] takeMask;
  logic [7:0] aluRes;
  logic aluCarry;
  logic aluOvf;
  logic isArith;
  logic isBreak;
  logic irqGo;
  logic busWrIreq;

  assign isArith = opReq.valid && (opReq.code == csf_pkg::CSF_ADD ||
                                   opReq.code == csf_pkg::CSF_SUB);
  assign isBreak = opReq.valid && opReq.code == csf_pkg::CSF_BREAK;
  // Maskable requests wait while the mask flag is set.
  assign irqGo = !opReq.valid && (|ireq_r) && !ps_r[csf_pkg::FLAG_I];
  assign busWrIreq = busReq.wr && busReq.addr == csf_pkg::OFS_IREQ;

  csf_bcd_alu u_alu (
    .opA(acc_r),
    .opB(opReq.data),
    .carryIn(ps_r[csf_pkg::FLAG_C]),
    .doSub(opReq.code == csf_pkg::CSF_SUB),
    .decMode(ps_r[csf_pkg::FLAG_D]),
    .result(aluRes),
    .carryOut(aluCarry),
    .ovfOut(aluOvf)
  );

  // Flags follow the selected operation; interrupts enter only when idle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ps_r <= csf_pkg::PS_RESET;
    end else if (clkEn) begin
      if (opReq.valid) begin
        unique case (opReq.code)
          csf_pkg::CSF_ADD, csf_pkg::CSF_SUB: begin
            ps_r[csf_pkg::FLAG_C] <= aluCarry;
            // In decimal mode these three hold no meaning.
            ps_r[csf_pkg::FLAG_Z] <= (aluRes == 8'h00);
            ps_r[csf_pkg::FLAG_N] <= aluRes[7];
            ps_r[csf_pkg::FLAG_V] <= aluOvf;
          end
          csf_pkg::CSF_SET_CARRY: ps_r[csf_pkg::FLAG_C] <= 1'b1;
          csf_pkg::CSF_CLR_CARRY: ps_r[csf_pkg::FLAG_C] <= 1'b0;
          csf_pkg::CSF_SET_DEC: ps_r[csf_pkg::FLAG_D] <= 1'b1;
          csf_pkg::CSF_CLR_DEC: ps_r[csf_pkg::FLAG_D] <= 1'b0;
          csf_pkg::CSF_SET_MASK: ps_r[csf_pkg::FLAG_I] <= 1'b1;
          csf_pkg::CSF_CLR_MASK: ps_r[csf_pkg::FLAG_I] <= 1'b0;
          csf_pkg::CSF_PULL_PS: ps_r <= opReq.data;
          csf_pkg::CSF_BREAK: ps_r[csf_pkg::FLAG_I] <= 1'b1;
          csf_pkg::CSF_NONE, csf_pkg::CSF_PUSH_PS, csf_pkg::CSF_NOP: begin
          end
          default: begin
          end
        endcase
      end else if (irqGo) begin
        ps_r[csf_pkg::FLAG_I] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_r <= csf_pkg::ACC_RESET;
    end else if (clkEn) begin
      if (isArith) begin
        acc_r <= aluRes;
      end else if (busReq.wr && busReq.addr == csf_pkg::OFS_ACC) begin
        acc_r <= busReq.wdata;
      end
    end
  end

  // Break and push store the break-source flag set; interrupts store it clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stackData_r <= 8'h00;
      stackWr_r <= 1'b0;
      vecTake_r <= 1'b0;
      entryBrk_r <= 1'b0;
    end else if (clkEn) begin
      stackWr_r <= 1'b0;
      vecTake_r <= 1'b0;
      if (isBreak || (opReq.valid && opReq.code == csf_pkg::CSF_PUSH_PS)) begin
        stackData_r <= ps_r | (8'h01 << csf_pkg::FLAG_B);
        stackWr_r <= 1'b1;
        vecTake_r <= isBreak;
        if (isBreak) begin
          entryBrk_r <= 1'b1;
        end
      end else if (irqGo) begin
        stackData_r <= ps_r & ~(8'h01 << csf_pkg::FLAG_B);
        stackWr_r <= 1'b1;
        vecTake_r <= 1'b1;
        entryBrk_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      lvl_r <= '0;
    end else if (clkEn) begin
      sync1_r <= extIntPin;
      sync2_r <= sync1_r;
      lvl_r <= detect;
    end
  end

  // The edge select flips the detected level, so changing it can raise a
  // request just as a pin edge would.
  assign detect = sync2_r ^ edgeSel_r;
  assign rise = detect & ~lvl_r;
  assign takeMask = irqGo ? (ireq_r & (~ireq_r + NUM_EXT'(1'b1))) : '0;

  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      clrBus[i] = busWrIreq && !busReq.wdata[csf_pkg::IREQ_LSB + i];
    end
    // A new edge wins over a clear in the same cycle.
    ireq_nxt = rise | (ireq_r & ~clrBus & ~takeMask);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ireq_r <= '0;
      ireqSeen_r <= '0;
      edgeSel_r <= '0;
    end else if (clkEn) begin
      ireq_r <= ireq_nxt;
      // Reads see the request bits one cycle late.
      ireqSeen_r <= ireq_r;
      if (busReq.wr && busReq.addr == csf_pkg::OFS_EDGE) begin
        edgeSel_r <= busReq.wdata[NUM_EXT-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= csf_pkg::RD_IDLE;
    end else if (clkEn) begin
      rdData_r <= csf_pkg::RD_IDLE;
      if (busReq.rd) begin
        unique case (busReq.addr)
          csf_pkg::OFS_STATUS: rdData_r <= ps_r;
          csf_pkg::OFS_IREQ: rdData_r <= 8'(ireqSeen_r) << csf_pkg::IREQ_LSB;
          csf_pkg::OFS_EDGE: rdData_r <= 8'(edgeSel_r);
          csf_pkg::OFS_ACC: rdData_r <= acc_r;
        endcase
      end
    end
  end

  assign rdData = rdData_r;
  assign status = ps_r;
  assign accOut = acc_r;
  assign stackData = stackData_r;
  assign stackWr = stackWr_r;
  assign vecTake = vecTake_r;
  assign entryBrk = entryBrk_r;

  // Helper logic watched only by the assertions below.
  logic afterRst_r;
  logic decAddRef;
  logic decSubRef;
  logic decArgsOk;
  logic [7:0] binAddRef;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      afterRst_r <= 1'b0;
    end else if (clkEn) begin
      afterRst_r <= 1'b1;
    end
  end
  assign decArgsOk = isBcd(acc_r) && isBcd(opReq.data);
  assign decAddRef = (bcdVal(acc_r) + bcdVal(opReq.data) +
                      {7'h00, ps_r[csf_pkg::FLAG_C]}) >= 8'h64;
  assign decSubRef = bcdVal(acc_r) >=
                     (bcdVal(opReq.data) + {7'h00, !ps_r[csf_pkg::FLAG_C]});
  assign binAddRef = acc_r + opReq.data + {7'h00, ps_r[csf_pkg::FLAG_C]};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_reset_mask_set: assert property (
    !afterRst_r |-> ps_r[csf_pkg::FLAG_I])
    else $error("mask flag not set after reset");

  a_dec_add_carry: assert property (
    clkEn && opReq.valid && opReq.code == csf_pkg::CSF_ADD &&
    ps_r[csf_pkg::FLAG_D] && decArgsOk
    |=> ps_r[csf_pkg::FLAG_C] == $past(decAddRef))
    else $error("decimal add carry wrong");

  a_dec_sub_borrow: assert property (
    clkEn && opReq.valid && opReq.code == csf_pkg::CSF_SUB &&
    ps_r[csf_pkg::FLAG_D] && decArgsOk
    |=> ps_r[csf_pkg::FLAG_C] == $past(decSubRef))
    else $error("decimal subtract borrow wrong");

  a_bin_add_plain: assert property (
    clkEn && opReq.valid && opReq.code == csf_pkg::CSF_ADD &&
    !ps_r[csf_pkg::FLAG_D]
    |=> acc_r == $past(binAddRef))
    else $error("binary add was corrected");

  a_stale_ireq_read: assert property (
    clkEn && busWrIreq ##1 clkEn && busReq.rd && busReq.addr ==
    csf_pkg::OFS_IREQ
    |=> rdData_r[csf_pkg::IREQ_LSB +: NUM_EXT] == $past(ireq_r, 2))
    else $error("request read not stale after clear");

  a_edge_sets_req: assert property (
    clkEn && (|rise) |=> (ireq_r & $past(rise)) == $past(rise))
    else $error("detected transition did not set request");

  a_brk_stack_flag: assert property (
    clkEn && isBreak |=> stackWr_r && vecTake_r && entryBrk_r &&
    stackData_r[csf_pkg::FLAG_B] && ps_r[csf_pkg::FLAG_I])
    else $error("break entry not marked");

  a_irq_stack_flag: assert property (
    clkEn && irqGo |=> stackWr_r && vecTake_r && !entryBrk_r &&
    !stackData_r[csf_pkg::FLAG_B])
    else $error("interrupt entry marked as break");

  a_mask_blocks_irq: assert property (
    clkEn && ps_r[csf_pkg::FLAG_I] && !isBreak |=> !vecTake_r)
    else $error("entry taken while masked");

  c_dec_carry: cover property (
    clkEn && isArith && ps_r[csf_pkg::FLAG_D] && aluCarry);
  c_brk_taken: cover property (clkEn && isBreak);
  c_irq_taken: cover property (clkEn && irqGo);
  c_stale_read: cover property (
    clkEn && busWrIreq ##1 clkEn && busReq.rd);

endmodule

// ---- sim/tb_top.sv ----
// Self-checking testbench for the status flag unit.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  csf_pkg::csf_bus_req_t busReq = '0;
  csf_pkg::csf_op_req_t opReq = '0;
  logic [1:0] extIntPin = 2'h0;
  logic [7:0] rdData;
  logic [7:0] status;
  logic [7:0] accOut;
  logic [7:0] stackData;
  logic stackWr;
  logic vecTake;
  logic entryBrk;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] rdv;
  logic [7:0] prev;

  always #5 ref_clk = ~ref_clk;

  cpu_status_flag_logic #(.NUM_EXT(2)) DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .busReq(busReq),
    .rdData(rdData),
    .opReq(opReq),
    .extIntPin(extIntPin),
    .status(status),
    .accOut(accOut),
    .stackData(stackData),
    .stackWr(stackWr),
    .vecTake(vecTake),
    .entryBrk(entryBrk)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    busReq <= '0;
  endtask

  task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    d = rdData;
  endtask

  // Issues one operation; returns with its results settled.
  task automatic do_op(input csf_pkg::csf_op_t c, input logic [7:0] d);
    @(posedge ref_clk);
    opReq <= '{valid: 1'b1, code: c, data: d};
    @(posedge ref_clk);
    opReq <= '0;
    #1;
  endtask

  task automatic test_decimal();
    do_op(csf_pkg::CSF_SET_DEC, 8'h00);
    bus_wr(csf_pkg::OFS_ACC, 8'h99);
    do_op(csf_pkg::CSF_CLR_CARRY, 8'h00);
    do_op(csf_pkg::CSF_ADD, 8'h01);
    check(accOut, 8'h00, "decimal add result");
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h01, "decimal carry");
    do_op(csf_pkg::CSF_SUB, 8'h01);
    check(accOut, 8'h99, "decimal sub result");
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h00, "decimal borrow");
    do_op(csf_pkg::CSF_NOP, 8'h00);
    do_op(csf_pkg::CSF_CLR_DEC, 8'h00);
    do_op(csf_pkg::CSF_ADD, 8'h01);
    check(accOut, 8'h9a, "binary add after clear");
    clkEn <= 1'b0;
    do_op(csf_pkg::CSF_SET_CARRY, 8'h00);
    clkEn <= 1'b1;
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h00, "frozen clock enable");
  endtask

  task automatic test_break_push();
    prev = status;
    do_op(csf_pkg::CSF_BREAK, 8'h00);
    check({6'h00, vecTake, entryBrk}, 8'h03, "break entry");
    check(stackData, prev | 8'h10, "break stacked status");
    prev = status;
    do_op(csf_pkg::CSF_PUSH_PS, 8'h00);
    check({6'h00, stackWr, vecTake}, 8'h02, "push strobe");
    check(stackData, prev | 8'h10, "pushed status");
    do_op(csf_pkg::CSF_PULL_PS, 8'h0d);
    do_op(csf_pkg::CSF_NOP, 8'h00);
    check(status, 8'h0d, "pulled status");
    bus_wr(csf_pkg::OFS_STATUS, 8'hff);
    bus_rd(csf_pkg::OFS_STATUS, rdv);
    check(rdv, 8'h0d, "status is read-only");
  endtask

  task automatic test_interrupts();
    int i;
    do_op(csf_pkg::CSF_CLR_MASK, 8'h00);
    extIntPin <= 2'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      #1;
      if (vecTake === 1'b1) break;
    end
    check({7'h00, vecTake}, 8'h01, "interrupt taken");
    check({7'h00, entryBrk}, 8'h00, "interrupt entry source");
    check({7'h00, stackData[csf_pkg::FLAG_B]}, 8'h00, "stacked break");
    check({7'h00, status[csf_pkg::FLAG_I]}, 8'h01, "mask set on entry");
    extIntPin <= 2'h3;
    for (i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #1;
      check({7'h00, vecTake}, 8'h00, "masked request refused");
    end
    bus_rd(csf_pkg::OFS_IREQ, rdv);
    check(rdv, 8'h04, "pending masked request");
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: csf_pkg::OFS_IREQ, wdata: 8'h00};
    @(posedge ref_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: csf_pkg::OFS_IREQ, wdata: 8'h00};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    check(rdData, 8'h04, "read right after clear");
    bus_rd(csf_pkg::OFS_IREQ, rdv);
    check(rdv, 8'h00, "read after clear settled");
  endtask

  // Walks the remaining flag ops and register reads; decimal is on from the start, left set by the pulled status, through the accumulator read.
  // The op port has no indirect jump, so no pointer sits at a page end.
  task automatic test_flags();
    do_op(csf_pkg::CSF_CLR_CARRY, 8'h00);
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h00, "carry cleared");
    do_op(csf_pkg::CSF_SET_CARRY, 8'h00);
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h01, "carry set");
    do_op(csf_pkg::CSF_SET_DEC, 8'h00);
    bus_wr(csf_pkg::OFS_ACC, 8'h42);
    do_op(csf_pkg::CSF_SUB, 8'h15);
    check(accOut, 8'h27, "decimal sub no borrow");
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h01, "no borrow");
    do_op(csf_pkg::CSF_NOP, 8'h00);
    do_op(csf_pkg::CSF_CLR_CARRY, 8'h00);
    do_op(csf_pkg::CSF_ADD, 8'h15);
    check(accOut, 8'h42, "decimal add no carry");
    check({7'h00, status[csf_pkg::FLAG_C]}, 8'h00, "no carry");
    bus_rd(csf_pkg::OFS_ACC, rdv);
    check(rdv, 8'h42, "accumulator read");
    do_op(csf_pkg::CSF_NOP, 8'h00);
    do_op(csf_pkg::CSF_CLR_DEC, 8'h00);
    do_op(csf_pkg::CSF_CLR_MASK, 8'h00);
    check({7'h00, status[csf_pkg::FLAG_I]}, 8'h00, "mask cleared");
    do_op(csf_pkg::CSF_SET_MASK, 8'h00);
    check({7'h00, status[csf_pkg::FLAG_I]}, 8'h01, "mask set");
    bus_wr(csf_pkg::OFS_EDGE, 8'h02);
    bus_rd(csf_pkg::OFS_EDGE, rdv);
    check(rdv, 8'h02, "edge select read");
    bus_wr(csf_pkg::OFS_EDGE, 8'h00);
    bus_wr(csf_pkg::OFS_IREQ, 8'h00);
    bus_rd(csf_pkg::OFS_IREQ, rdv);
    check(rdv, 8'h00, "spurious request cleared");
  endtask

  // Lowers pin 0 under rising detection, then turns it to falling.
  task automatic test_edge_switch();
    extIntPin <= 2'h2;
    repeat (6) @(posedge ref_clk);
    bus_wr(csf_pkg::OFS_IREQ, 8'h00);
    repeat (3) @(posedge ref_clk);
    bus_rd(csf_pkg::OFS_IREQ, rdv);
    check(rdv, 8'h00, "no request before switch");
    bus_wr(csf_pkg::OFS_EDGE, 8'h01);
    repeat (6) @(posedge ref_clk);
    bus_rd(csf_pkg::OFS_IREQ, rdv);
    check(rdv, 8'h02, "spurious request from switch");
  endtask

  initial begin
    #50000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check({7'h00, status[csf_pkg::FLAG_I]}, 8'h01, "mask after reset");
    check(rdData, 8'h00, "idle read data");
    test_decimal();
    test_break_push();
    test_flags();
    test_interrupts();
    test_edge_switch();
    complete_run();
  end
endmodule
